// ==== emeter_cfg.svh ====
// Purpose: constants for the energy offset and phase trim stage
// Assumes: one 200 MHz master clock, word-wide register port
// Notes: register offsets are word indices on the plain port
`ifndef EMETER_CFG_SVH
`define EMETER_CFG_SVH

// register offsets
`define ADDR_CTRL 4'h0
`define ADDR_OFFSET 4'h1
`define ADDR_TRIM 4'h2
`define ADDR_HALF_CYC 4'h3
`define ADDR_ENERGY 4'h4
`define ADDR_LINE_ENERGY 4'h5
`define ADDR_PERIOD 4'h6
`define ADDR_STATUS 4'h7

// field positions
`define CTRL_LINE_MODE_BIT 0
`define STATUS_LINE_DONE_BIT 0

// reset values and neutral trim code
`define OFFSET_RST 16'h0000
`define TRIM_RST 6'h0D
`define TRIM_NEUTRAL 6'h0D
`define HALF_CYC_RST 16'hFFFF

// widths and positions of the datapath
`define SAMPLE_W 16
`define OFFSET_W 16
`define TRIM_W 6
`define CNT_W 16
`define FRAC_BITS 8
`define ENERGY_W 57
`define READ_LSB 33
`define READ_W 24
`define DLY_TAPS 64
`define CURR_TAP 45

// timing: clock period in ns, other counts in master clocks
`define CLK_PERIOD_NS 5
`define UPD_CLKS 4
`define STEP_CLKS 8
`define UPD_LAST 2'h3
`define STEP_LAST 3'h7

`endif

// ==== emeter_pkg.sv ====
// Purpose: types shared by the energy offset and phase trim stage
// Assumes: emeter_cfg.svh holds every datapath width; port fields and the update and step counters use literals
// Notes: whole block state is one packed struct
`include "emeter_cfg.svh"

package emeter_pkg;

	typedef logic signed [`SAMPLE_W-1:0] sample_t;

	typedef struct packed {
		logic [3:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} reg_req_s;

	typedef struct packed {
		logic line_mode;
		logic [`OFFSET_W-1:0] offset;
		logic [`TRIM_W-1:0] trim;
		logic [`CNT_W-1:0] half_cyc;
		logic [`CNT_W-1:0] hc_cnt;
		logic [1:0] upd_cnt;
		logic [2:0] step_cnt;
		logic [`DLY_TAPS-1:0][`SAMPLE_W-1:0] vtap;
		logic [`CURR_TAP:0][`SAMPLE_W-1:0] itap;
		logic [2*`SAMPLE_W-1:0] pwr;
		logic [`ENERGY_W-1:0] energy;
		logic [`ENERGY_W-1:0] line_acc;
		logic [`READ_W-1:0] line_energy;
		logic [`CNT_W-1:0] period_cnt;
		logic [`CNT_W-1:0] period;
		logic zx_phase;
		logic line_done;
		logic [31:0] rdata;
	} state_s;

endpackage

// ==== energy_offset_phase_trim.sv ====
// Purpose: active power offset and voltage phase trim of an energy meter
// Assumes: samples and zero crossings come from logic on sys_clk
// Notes: all state is one struct, filled by one comb and one ff process
// Function
// - energy accumulates once every four master clocks
// - offset word is signed and finely trims computed power
// - offset added as fixed power each four-clock update period
// - low eight offset bits are fractional, 1/256 internal energy LSB
// - one offset step is 2^-33 of readable 24-bit energy step
// - phase corrected by shifting voltage samples against current
// - voltage shift is (trim minus 13) times eight master clocks
// - positive difference delays voltage, negative advances it
// - trim of thirteen gives no voltage shift
// - corrects up to 0.032 degrees (1.8 us) lead and 0.013 (0.72 us) lag at 50 Hz
// - trim word read as signed two's complement
// - line mode accumulates over host-set number of half cycles
// - measured line period is readable by the host
`timescale 1ns/1ps
`default_nettype none
`include "emeter_cfg.svh"

module energy_offset_phase_trim (
	// clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// register port
	input wire emeter_pkg::reg_req_s bus_req,
	output logic [31:0] reg_rdata,
	// sample stream
	input wire emeter_pkg::sample_t volt_sample,
	input wire emeter_pkg::sample_t curr_sample,
	input wire logic zero_cross,
	// status
	output logic line_ready
);
	import emeter_pkg::*;

	state_s st_ff;
	state_s nxt_st;
	logic [5:0] vsel;
	logic upd_tick;
	logic step_tick;
	logic signed [2*`SAMPLE_W-1:0] prod;
	logic [`ENERGY_W-1:0] pwr_ext;
	logic [`ENERGY_W-1:0] off_ext;
	logic [`ENERGY_W-1:0] incr;
	logic [`CNT_W-1:0] hc_next;

	// signed trim, biased by half the tap range
	// flipping the sign bit adds 32, so no adder sits in the tap path
	// negative codes pick shallower taps, an advance
	// 64 taps give 45 steps of lead and 18 of lag
	always_comb begin
		vsel = {~st_ff.trim[`TRIM_W-1], st_ff.trim[`TRIM_W-2:0]};
	end

	assign upd_tick = (st_ff.upd_cnt == `UPD_LAST);
	assign step_tick = (st_ff.step_cnt == `STEP_LAST);

	// voltage tap against fixed current tap
	assign prod = $signed(st_ff.vtap[vsel]) * $signed(st_ff.itap[`CURR_TAP]);

	// power sits above the fraction, offset sign-extended
	assign pwr_ext = {{(`ENERGY_W-2*`SAMPLE_W-`FRAC_BITS){st_ff.pwr[2*`SAMPLE_W-1]}},
		st_ff.pwr, {`FRAC_BITS{1'b0}}};
	assign off_ext = {{(`ENERGY_W-`OFFSET_W){st_ff.offset[`OFFSET_W-1]}}, st_ff.offset};
	// fraction of the internal LSB kept in the low bits
	assign incr = pwr_ext + off_ext;
	assign hc_next = st_ff.hc_cnt + `CNT_W'(1);

	always_comb begin
		nxt_st = st_ff;
		nxt_st.rdata = 32'h0000_0000;
		nxt_st.upd_cnt = st_ff.upd_cnt + 2'h1;
		nxt_st.step_cnt = st_ff.step_cnt + 3'h1;
		nxt_st.pwr = prod;

		// register writes first, so hardware events below win
		if (bus_req.wr) begin
			unique case (bus_req.addr)
				`ADDR_CTRL: begin
					nxt_st.line_mode = bus_req.wdata[`CTRL_LINE_MODE_BIT];
				end
				`ADDR_OFFSET: begin
					nxt_st.offset = bus_req.wdata[`OFFSET_W-1:0];
				end
				`ADDR_TRIM: begin
					nxt_st.trim = bus_req.wdata[`TRIM_W-1:0];
				end
				`ADDR_HALF_CYC: begin
					nxt_st.half_cyc = bus_req.wdata[`CNT_W-1:0];
				end
				`ADDR_STATUS: begin
					if (bus_req.wdata[`STATUS_LINE_DONE_BIT]) begin
						nxt_st.line_done = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end

		// delay line moves one step every eight clocks
		if (step_tick) begin
			nxt_st.vtap = {st_ff.vtap[`DLY_TAPS-2:0], volt_sample};
			nxt_st.itap = {st_ff.itap[`CURR_TAP-1:0], curr_sample};
		end

		if (upd_tick) begin
			nxt_st.energy = st_ff.energy + incr;
			if (st_ff.line_mode) begin
				nxt_st.line_acc = st_ff.line_acc + incr;
			end
		end

		// period in units of eight clocks, saturating
		if (step_tick && (st_ff.period_cnt != {`CNT_W{1'b1}})) begin
			nxt_st.period_cnt = st_ff.period_cnt + `CNT_W'(1);
		end

		if (zero_cross) begin
			nxt_st.zx_phase = ~st_ff.zx_phase;
			// full line period spans two crossings
			if (st_ff.zx_phase) begin
				nxt_st.period = st_ff.period_cnt;
				nxt_st.period_cnt = {`CNT_W{1'b0}};
			end
			// count half cycles, latch at the host's figure
			if (st_ff.line_mode) begin
				if (hc_next >= st_ff.half_cyc) begin
					nxt_st.hc_cnt = {`CNT_W{1'b0}};
					nxt_st.line_energy = st_ff.line_acc[`READ_LSB+`READ_W-1:`READ_LSB];
					nxt_st.line_acc = {`ENERGY_W{1'b0}};
					nxt_st.line_done = 1'b1;
				end else begin
					nxt_st.hc_cnt = hc_next;
				end
			end
		end

		// leaving line mode restarts the window cleanly
		if (!st_ff.line_mode) begin
			nxt_st.hc_cnt = {`CNT_W{1'b0}};
			nxt_st.line_acc = {`ENERGY_W{1'b0}};
		end

		if (bus_req.rd) begin
			unique case (bus_req.addr)
				`ADDR_CTRL: begin
					nxt_st.rdata[`CTRL_LINE_MODE_BIT] = st_ff.line_mode;
				end
				`ADDR_OFFSET: begin
					nxt_st.rdata[`OFFSET_W-1:0] = st_ff.offset;
				end
				`ADDR_TRIM: begin
					nxt_st.rdata[`TRIM_W-1:0] = st_ff.trim;
				end
				`ADDR_HALF_CYC: begin
					nxt_st.rdata[`CNT_W-1:0] = st_ff.half_cyc;
				end
				// readable word starts 33 bits above the offset LSB
				`ADDR_ENERGY: begin
					nxt_st.rdata[`READ_W-1:0] = st_ff.energy[`READ_LSB+`READ_W-1:`READ_LSB];
				end
				`ADDR_LINE_ENERGY: begin
					nxt_st.rdata[`READ_W-1:0] = st_ff.line_energy;
				end
				`ADDR_PERIOD: begin
					nxt_st.rdata[`CNT_W-1:0] = st_ff.period;
				end
				`ADDR_STATUS: begin
					nxt_st.rdata[`STATUS_LINE_DONE_BIT] = st_ff.line_done;
				end
				default: begin
					nxt_st.rdata = 32'h0000_0000;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_ff <= '0;
			st_ff.offset <= `OFFSET_RST;
			st_ff.trim <= `TRIM_RST;
			st_ff.half_cyc <= `HALF_CYC_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign reg_rdata = st_ff.rdata;
	assign line_ready = st_ff.line_done;

	// checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	energy_rate_a: assert property (
		$changed(st_ff.energy) |-> $past(st_ff.upd_cnt) == `UPD_LAST
	) else $error("energy moved outside the four-clock update");

	upd_spacing_a: assert property (
		upd_tick |=> !upd_tick [*3] ##1 upd_tick
	) else $error("update ticks not four clocks apart");

	offset_add_a: assert property (
		(upd_tick && st_ff.pwr == '0)
		|=> st_ff.energy == $past(st_ff.energy) + $past(off_ext)
	) else $error("offset not added as fixed power");

	frac_align_a: assert property (
		(upd_tick && st_ff.pwr == '0 && st_ff.offset == 16'h0100)
		|=> st_ff.energy - $past(st_ff.energy) == 57'h100
	) else $error("offset fraction misaligned");

	energy_read_a: assert property (
		(bus_req.rd && bus_req.addr == `ADDR_ENERGY)
		|=> reg_rdata == {8'h00, $past(st_ff.energy[56:33])}
	) else $error("energy readout at wrong bit position");

	step_period_a: assert property (
		$changed(st_ff.vtap) |-> $past(st_ff.step_cnt) == `STEP_LAST
	) else $error("delay line stepped off the eight-clock grid");

	vtap_follow_a: assert property (
		step_tick |=> st_ff.vtap[0] == $past(volt_sample)
			&& st_ff.vtap[1] == $past(st_ff.vtap[0])
	) else $error("voltage delay line lost a sample");

	pos_delay_a: assert property (
		!st_ff.trim[5] |-> vsel == 6'(st_ff.trim[4:0]) + 6'h20
	) else $error("positive trim picked wrong tap");

	neg_advance_a: assert property (
		st_ff.trim[5] |-> vsel == 6'(st_ff.trim[4:0])
	) else $error("negative trim not treated as signed");

	neutral_a: assert property (
		st_ff.trim == `TRIM_NEUTRAL |-> vsel == `CURR_TAP
	) else $error("neutral trim still shifts voltage");

	pwr_pair_a: assert property (
		##1 st_ff.pwr == $past(prod)
	) else $error("power not taken from the selected taps");

	line_latch_a: assert property (
		$rose(st_ff.line_done) |-> $past(zero_cross && st_ff.line_mode)
	) else $error("line window closed without a crossing");

	period_a: assert property (
		(zero_cross && st_ff.zx_phase) |=> st_ff.period == $past(st_ff.period_cnt)
			&& st_ff.period_cnt == '0
	) else $error("period not captured at full cycle");

	// period counter runs only on the eight-clock grid
	period_count_a: assert property (
		(step_tick && !zero_cross && st_ff.period_cnt != 16'hFFFF)
		|=> st_ff.period_cnt == $past(st_ff.period_cnt) + 16'h0001
	) else $error("period counter missed a step");

	energy_hold_a: assert property (
		!upd_tick
		|=> $stable(st_ff.energy)
	) else $error("energy moved between updates");

	step_spacing_a: assert property (
		step_tick
		|=> !step_tick [*7] ##1 step_tick
	) else $error("step ticks not eight clocks apart");

	itap_follow_a: assert property (
		step_tick
		|=> st_ff.itap[0] == $past(curr_sample)
	) else $error("current delay line lost a sample");

	offset_write_a: assert property (
		(bus_req.wr && bus_req.addr == `ADDR_OFFSET)
		|=> st_ff.offset == $past(bus_req.wdata[15:0])
	) else $error("offset write not taken");

	trim_write_a: assert property (
		(bus_req.wr && bus_req.addr == `ADDR_TRIM)
		|=> st_ff.trim == $past(bus_req.wdata[5:0])
	) else $error("trim write not taken");

	trim_read_a: assert property (
		(bus_req.rd && bus_req.addr == `ADDR_TRIM)
		|=> reg_rdata == {26'h0, $past(st_ff.trim)}
	) else $error("trim readout wrong");

	// read data must fall back to zero so a stale word is never mistaken
	read_idle_a: assert property (
		!bus_req.rd
		|=> reg_rdata == 32'h0000_0000
	) else $error("read data left standing");

	// window accumulator sums the same corrected power as the main one
	line_acc_a: assert property (
		(upd_tick && st_ff.line_mode && !zero_cross)
		|=> st_ff.line_acc == $past(st_ff.line_acc) + $past(incr)
	) else $error("line window lost an update");

	line_energy_a: assert property (
		(zero_cross && st_ff.line_mode && hc_next >= st_ff.half_cyc)
		|=> st_ff.line_energy == $past(st_ff.line_acc[`READ_LSB+`READ_W-1:`READ_LSB])
	) else $error("line energy not latched at window end");

	mode_off_a: assert property (
		!st_ff.line_mode
		|=> st_ff.hc_cnt == '0 && st_ff.line_acc == '0
	) else $error("line window ran with mode off");

	// a clear racing the closing crossing must lose
	line_clear_a: assert property (
		(bus_req.wr && bus_req.addr == `ADDR_STATUS && bus_req.wdata[0] && !zero_cross)
		|=> !st_ff.line_done
	) else $error("status clear not taken");

	line_hold_a: assert property (
		(st_ff.line_done && !(bus_req.wr && bus_req.addr == `ADDR_STATUS))
		|=> st_ff.line_done
	) else $error("line done dropped by itself");

endmodule
`default_nettype wire

// ==== tb_energy_offset_phase_trim.sv ====
// Purpose: self-checking bench for energy_offset_phase_trim
// Assumes: read data stands only in the cycle after the read strobe
// Notes: phase trim is judged by when a voltage step reaches the energy reading
`timescale 1ns/1ps
`default_nettype none
`include "emeter_cfg.svh"

module tb_energy_offset_phase_trim;
	import emeter_pkg::*;
	typedef struct {logic [3:0] a; logic [31:0] w; logic [31:0] e;} row_s;
	logic sys_clk, sys_rst, zero_cross, line_ready;
	reg_req_s bus_req;
	logic [31:0] reg_rdata, v;
	sample_t volt_sample, curr_sample;
	int n_fail, checks, d13, d;
	int cyc = 0;
	row_s rows[6] = '{
		'{`ADDR_OFFSET, 32'h0000_1234, 32'h0000_1234},
		'{`ADDR_TRIM, 32'hFFFF_FFFF, 32'h0000_003F},
		'{`ADDR_HALF_CYC, 32'hFFFF_ABCD, 32'h0000_ABCD},
		'{`ADDR_CTRL, 32'h0000_0003, 32'h0000_0001},
		'{`ADDR_ENERGY, 32'h00FF_FFFF, 32'h0000_0000},
		'{4'h9, 32'h0000_FFFF, 32'h0000_0000}};
	logic [5:0] trims[5] = '{6'h0F, 6'h0A, 6'h1F, 6'h20, 6'h3E};
	int steps[5] = '{2, -3, 18, -45, -15};

	energy_offset_phase_trim DUT (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.bus_req(bus_req),
		.reg_rdata(reg_rdata),
		.volt_sample(volt_sample),
		.curr_sample(curr_sample),
		.zero_cross(zero_cross),
		.line_ready(line_ready)
	);

	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] w);
		@(posedge sys_clk);
		bus_req <= '{addr: a, wdata: w, wr: 1'b1, rd: 1'b0};
		@(posedge sys_clk);
		bus_req.wr <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, output logic [31:0] r);
		@(posedge sys_clk);
		bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge sys_clk);
		bus_req.rd <= 1'b0;
		#1 r = reg_rdata;
	endtask

	task automatic do_rst;
		@(posedge sys_clk);
		sys_rst <= 1'b1;
		repeat (12) @(posedge sys_clk);
		sys_rst <= 1'b0;
		volt_sample <= 16'h0000;
	endtask

	task automatic pulse;
		@(posedge sys_clk);
		zero_cross <= 1'b1;
		@(posedge sys_clk);
		zero_cross <= 1'b0;
		#1;
	endtask

	// delay from a voltage step to the first visible energy, current held full scale
	task automatic measure(input logic [5:0] t, output int r);
		int t0;
		do_rst;
		wr(`ADDR_TRIM, {26'h0, t});
		// current must fill all 46 taps first
		repeat (400) @(posedge sys_clk);
		volt_sample <= 16'h7FFF;
		t0 = cyc;
		v = 32'h0;
		while (v === 32'h0 && cyc - t0 < 800) rd(`ADDR_ENERGY, v);
		r = cyc - t0;
	endtask

	task automatic wrap_up;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// cut a hang short
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			wrap_up;
		end
	end

	initial begin
		sys_rst = 1'b1;
		bus_req = '0;
		volt_sample = 16'h0000;
		curr_sample = 16'h7FFF;
		zero_cross = 1'b0;
		n_fail = 0;
		checks = 0;
		repeat (12) @(posedge sys_clk);
		sys_rst <= 1'b0;
		foreach (rows[k]) begin
			wr(rows[k].a, rows[k].w);
			rd(rows[k].a, v);
			chk("register", v, rows[k].e);
		end
		do_rst;
		rd(`ADDR_TRIM, v);
		chk("trim reset", v, 32'h0000_000D);
		rd(`ADDR_HALF_CYC, v);
		chk("half cycle reset", v, 32'h0000_FFFF);
		// no gain stage here, so offset goes in straight away
		// a negative offset must drive the readable energy below zero
		wr(`ADDR_OFFSET, 32'h0000_FFFF);
		repeat (8) @(posedge sys_clk);
		rd(`ADDR_ENERGY, v);
		chk("negative offset", v, 32'h00FF_FFFF);
		do_rst;
		wr(`ADDR_OFFSET, 32'h0000_7FFF);
		repeat (8) @(posedge sys_clk);
		rd(`ADDR_ENERGY, v);
		chk("positive offset", v, 32'h0000_0000);
		wr(`ADDR_OFFSET, 32'h0000_0100);
		repeat (8) @(posedge sys_clk);
		rd(`ADDR_ENERGY, v);
		chk("unit offset", v, 32'h0000_0000);
		measure(6'h0D, d13);
		// trims across the range, including the full lead and lag ends
		foreach (trims[k]) begin
			measure(trims[k], d);
			chk("trim delay", 32'(d), 32'(d13 + 8 * steps[k]));
		end
		do_rst;
		wr(`ADDR_HALF_CYC, 32'h0000_0002);
		pulse;
		pulse;
		chk("ready mode off", {31'h0, line_ready}, 32'h0);
		wr(`ADDR_CTRL, 32'h0000_0001);
		pulse;
		chk("ready early", {31'h0, line_ready}, 32'h0);
		pulse;
		chk("ready", {31'h0, line_ready}, 32'h1);
		rd(`ADDR_STATUS, v);
		chk("status", v, 32'h0000_0001);
		wr(`ADDR_STATUS, 32'h0000_0001);
		#1;
		chk("ready cleared", {31'h0, line_ready}, 32'h0);
		wrap_up;
	end
endmodule
`default_nettype wire
